// [core/ddccfg_defines.vh]
/*
 * Register offsets, field positions, reset values and constants for the
 * down-converter channel configuration and gain control block.
 * Assumes a 16-bit register port with word offsets.
 */
`ifndef DDCCFG_DEFINES_VH
`define DDCCFG_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define DDCCFG_OFS_CHAN_CTRL   5'h0e
`define DDCCFG_OFS_PROBE_CTRL  5'h0f
`define DDCCFG_OFS_STEP_SHIFT  5'h10
`define DDCCFG_OFS_MASK_RND    5'h11
`define DDCCFG_OFS_HOLD_RUNS   5'h12
`define DDCCFG_OFS_GAIN_UPPER  5'h13
`define DDCCFG_OFS_GAIN_A_LOW  5'h14
`define DDCCFG_OFS_GAIN_B_LOW  5'h15
`define DDCCFG_OFS_RISE_LIMIT  5'h16
`define DDCCFG_OFS_FALL_LIMIT  5'h17
`define DDCCFG_OFS_SYNC_SEL    5'h1c
`define DDCCFG_OFS_STATUS      5'h1e

// ----------------------------------------------------------------------
// Channel control fields
// ----------------------------------------------------------------------
`define DDCCFG_DITHER_EN       15
`define DDCCFG_DITHER_MSK_HI   14
`define DDCCFG_DITHER_MSK_LO   13
`define DDCCFG_PMETER_SYNC_OFF 12
`define DDCCFG_CHAN_EN         11
`define DDCCFG_INTERLEAVE      10
`define DDCCFG_MIX_BOOST       9
`define DDCCFG_COEF_READ       8
`define DDCCFG_Q_ZERO          2
`define DDCCFG_SLOT            1
`define DDCCFG_STREAMS         0

// Gain load sync field in the sync select register
`define DDCCFG_GSYNC_HI        6
`define DDCCFG_GSYNC_LO        4
`define DDCCFG_GSYNC_COUNTER   3'h4
`define DDCCFG_GSYNC_ONESHOT   3'h5
`define DDCCFG_GSYNC_ZERO      3'h6

// Hold and runs fields
`define DDCCFG_HOLD_BIT        12
`define DDCCFG_CLEAR_BIT       4

// ----------------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------------
`define DDCCFG_RST16           16'h0000
`define DDCCFG_RST24           24'h000000
`define DDCCFG_PROBE_W         36
`define DDCCFG_DATA_W          18
`define DDCCFG_FULL_SCALE      18'h1ffff
`define DDCCFG_ZERO_MASK_W     4

// Probe selection codes
`define DDCCFG_PRB_ZERO        6'h00
`define DDCCFG_PRB_PULSE       6'h01
`define DDCCFG_PRB_COMP        6'h02
`define DDCCFG_PRB_TADJ_A      6'h03
`define DDCCFG_PRB_TADJ_B      6'h04
`define DDCCFG_PRB_SINE        6'h05
`define DDCCFG_PRB_COSINE      6'h06
`define DDCCFG_PRB_CIC         6'h07
`define DDCCFG_PRB_AGC         6'h08
`define DDCCFG_PRB_MIX_A       6'h09
`define DDCCFG_PRB_MIX_B       6'h0a
`define DDCCFG_PRB_MUX_A       6'h0b
`define DDCCFG_PRB_MUX_B       6'h0c

`endif

// [core/ddccfg_top.v]
/*
 * One down-converter channel's configuration register group with its
 * automatic gain control, dither gating, input slot pick, probe bus.
 * Assumes a single 200 MHz clock, datapath inputs already on that clock
 * and sync pulses arriving from pins (synchronised here).
 */
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "ddccfg_defines.vh"

module ddccfg_top (
    input  wire        clk,
    input  wire        nrst,
    input  wire        clk_en,
    input  wire [4:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata_ff,
    input  wire [3:0]  rx_sync_pins,
    input  wire        chan_sync_count,
    input  wire        pmeter_sync_in,
    input  wire [15:0] coef_rdata,
    input  wire [17:0] mux_i,
    input  wire [17:0] mux_q,
    input  wire [17:0] mixer_i,
    input  wire [17:0] mixer_q,
    input  wire [15:0] dither_word,
    input  wire [35:0] tap_pulse,
    input  wire [35:0] tap_comp,
    input  wire [35:0] tap_tadj_a,
    input  wire [35:0] tap_tadj_b,
    input  wire [19:0] tap_sine,
    input  wire [19:0] tap_cosine,
    input  wire [35:0] tap_cic,
    input  wire [35:0] tap_mix_b,
    input  wire        filt_sync,
    input  wire [17:0] agc_in_i,
    input  wire [17:0] agc_in_q,
    output reg         chan_run_ff,
    output reg         pmeter_sync_ff,
    output reg  [15:0] dither_out_ff,
    output reg  [17:0] mix_in_i_ff,
    output reg  [17:0] mix_in_q_ff,
    output reg  [17:0] mix_out_i_ff,
    output reg  [17:0] mix_out_q_ff,
    output reg         out_valid_ff,
    output reg  [35:0] probe_bus_ff,
    output reg         probe_sync_ff,
    output reg         probe_agc_flag_ff,
    output reg  [17:0] agc_out_i_ff,
    output reg  [17:0] agc_out_q_ff,
    output reg  [23:0] gain_applied_ff
);

// ----------------------------------------------------------------------
// Reset release and pin synchronisers
// ----------------------------------------------------------------------
reg        rst_a_ff;
reg        rst_b_ff;
reg  [3:0] sync_m_ff;
reg  [3:0] sync_s_ff;
reg        sync_prev_ff;
wire       rst_n = rst_b_ff;

// Reset release through two flops
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        rst_a_ff <= 1'b0;
        rst_b_ff <= 1'b0;
    end else begin
        rst_a_ff <= 1'b1;
        rst_b_ff <= rst_a_ff;
    end
end

// Sync pins pass two flops before use
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        sync_m_ff <= 4'h0;
        sync_s_ff <= 4'h0;
    end else if (clk_en) begin
        sync_m_ff <= rx_sync_pins;
        sync_s_ff <= sync_m_ff;
    end
end

// ----------------------------------------------------------------------
// Registers
// ----------------------------------------------------------------------
reg [15:0] chan_ctrl_ff;
reg [15:0] probe_ctrl_ff;
reg [15:0] step_shift_ff;
reg [15:0] mask_rnd_ff;
reg [15:0] hold_runs_ff;
reg [15:0] gain_upper_ff;
reg [15:0] gain_a_low_ff;
reg [15:0] gain_b_low_ff;
reg [15:0] rise_limit_ff;
reg [15:0] fall_limit_ff;
reg [15:0] sync_sel_ff;
reg        oneshot_ff;
reg [23:0] gain_a_live_ff;
reg [23:0] gain_b_live_ff;
reg        gain_load_seen_ff;
reg        sat_seen_ff;

// Host writes; a write to the sync select register fires the one-shot
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        chan_ctrl_ff  <= `DDCCFG_RST16;
        probe_ctrl_ff <= `DDCCFG_RST16;
        step_shift_ff <= `DDCCFG_RST16;
        mask_rnd_ff   <= `DDCCFG_RST16;
        hold_runs_ff  <= `DDCCFG_RST16;
        gain_upper_ff <= `DDCCFG_RST16;
        gain_a_low_ff <= `DDCCFG_RST16;
        gain_b_low_ff <= `DDCCFG_RST16;
        rise_limit_ff <= `DDCCFG_RST16;
        fall_limit_ff <= `DDCCFG_RST16;
        sync_sel_ff   <= `DDCCFG_RST16;
        oneshot_ff    <= 1'b0;
    end else if (clk_en) begin
        oneshot_ff <= reg_wr && (reg_addr == `DDCCFG_OFS_SYNC_SEL);
        if (reg_wr) begin
            case (reg_addr)
                `DDCCFG_OFS_CHAN_CTRL:  chan_ctrl_ff  <= reg_wdata & 16'hff07;
                `DDCCFG_OFS_PROBE_CTRL: probe_ctrl_ff <= reg_wdata & 16'h003f;
                `DDCCFG_OFS_STEP_SHIFT: step_shift_ff <= reg_wdata;
                `DDCCFG_OFS_MASK_RND:   mask_rnd_ff   <= reg_wdata;
                `DDCCFG_OFS_HOLD_RUNS:  hold_runs_ff  <= reg_wdata & 16'h1f1f;
                `DDCCFG_OFS_GAIN_UPPER: gain_upper_ff <= reg_wdata;
                `DDCCFG_OFS_GAIN_A_LOW: gain_a_low_ff <= reg_wdata;
                `DDCCFG_OFS_GAIN_B_LOW: gain_b_low_ff <= reg_wdata;
                `DDCCFG_OFS_RISE_LIMIT: rise_limit_ff <= reg_wdata;
                `DDCCFG_OFS_FALL_LIMIT: fall_limit_ff <= reg_wdata;
                `DDCCFG_OFS_SYNC_SEL:   sync_sel_ff   <= reg_wdata & 16'h0070;
                default: ;
            endcase
        end
    end
end

// Readback, one cycle after the read strobe; readback bit routes RAMs
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        reg_rdata_ff <= `DDCCFG_RST16;
    end else if (clk_en) begin
        reg_rdata_ff <= 16'h0000;
        if (reg_rd && chan_ctrl_ff[`DDCCFG_COEF_READ]) begin
            reg_rdata_ff <= coef_rdata;
        end else if (reg_rd) begin
            case (reg_addr)
                `DDCCFG_OFS_CHAN_CTRL:  reg_rdata_ff <= chan_ctrl_ff;
                `DDCCFG_OFS_PROBE_CTRL: reg_rdata_ff <= probe_ctrl_ff;
                `DDCCFG_OFS_STEP_SHIFT: reg_rdata_ff <= step_shift_ff;
                `DDCCFG_OFS_MASK_RND:   reg_rdata_ff <= mask_rnd_ff;
                `DDCCFG_OFS_HOLD_RUNS:  reg_rdata_ff <= hold_runs_ff;
                `DDCCFG_OFS_GAIN_UPPER: reg_rdata_ff <= gain_upper_ff;
                `DDCCFG_OFS_GAIN_A_LOW: reg_rdata_ff <= gain_a_low_ff;
                `DDCCFG_OFS_GAIN_B_LOW: reg_rdata_ff <= gain_b_low_ff;
                `DDCCFG_OFS_RISE_LIMIT: reg_rdata_ff <= rise_limit_ff;
                `DDCCFG_OFS_FALL_LIMIT: reg_rdata_ff <= fall_limit_ff;
                `DDCCFG_OFS_SYNC_SEL:   reg_rdata_ff <= sync_sel_ff;
                `DDCCFG_OFS_STATUS:     reg_rdata_ff <= {14'h0000, sat_seen_ff,
                                                         gain_load_seen_ff};
                default:                reg_rdata_ff <= 16'h0000;
            endcase
        end
    end
end

// ----------------------------------------------------------------------
// Gain load sync and double buffer
// ----------------------------------------------------------------------
wire [2:0] gsel = sync_sel_ff[`DDCCFG_GSYNC_HI:`DDCCFG_GSYNC_LO];
reg        gain_load;

// Sync source choice
always @* begin
    case (gsel)
        3'h0, 3'h1, 3'h2, 3'h3: gain_load = sync_s_ff[gsel[1:0]];
        `DDCCFG_GSYNC_COUNTER:  gain_load = chan_sync_count;
        `DDCCFG_GSYNC_ONESHOT:  gain_load = oneshot_ff;
        `DDCCFG_GSYNC_ZERO:     gain_load = 1'b0;
        default:                gain_load = 1'b1;
    endcase
end

// Live gains take the holding words on the sync
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        gain_a_live_ff    <= `DDCCFG_RST24;
        gain_b_live_ff    <= `DDCCFG_RST24;
        gain_load_seen_ff <= 1'b0;
    end else if (clk_en) begin
        if (gain_load) begin
            gain_a_live_ff    <= {gain_upper_ff[15:8], gain_a_low_ff};
            gain_b_live_ff    <= {gain_upper_ff[7:0], gain_b_low_ff};
            gain_load_seen_ff <= 1'b1;
        end
    end
end

// ----------------------------------------------------------------------
// Channel path: enable, stream slot, mixer input and boost, dither
// ----------------------------------------------------------------------
wire run = clk_en & chan_ctrl_ff[`DDCCFG_CHAN_EN];
reg  phase_ff;
wire slot_hit = !chan_ctrl_ff[`DDCCFG_STREAMS] ||
                (phase_ff == chan_ctrl_ff[`DDCCFG_SLOT]);
wire take = !chan_ctrl_ff[`DDCCFG_INTERLEAVE] || slot_hit;
reg  [18:0] boost_i;
reg  [18:0] boost_q;

// Mixer boost: shift left, then saturate to 18 bits
always @* begin
    boost_i = chan_ctrl_ff[`DDCCFG_MIX_BOOST] ? {mixer_i, 1'b0} : {mixer_i[17], mixer_i};
    boost_q = chan_ctrl_ff[`DDCCFG_MIX_BOOST] ? {mixer_q, 1'b0} : {mixer_q[17], mixer_q};
end

// Clocked channel datapath
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        chan_run_ff    <= 1'b0;
        pmeter_sync_ff <= 1'b0;
        phase_ff       <= 1'b0;
        dither_out_ff  <= `DDCCFG_RST16;
        mix_in_i_ff    <= 18'h00000;
        mix_in_q_ff    <= 18'h00000;
        mix_out_i_ff   <= 18'h00000;
        mix_out_q_ff   <= 18'h00000;
        out_valid_ff   <= 1'b0;
    end else if (clk_en) begin
        chan_run_ff    <= chan_ctrl_ff[`DDCCFG_CHAN_EN];
        pmeter_sync_ff <= pmeter_sync_in & ~chan_ctrl_ff[`DDCCFG_PMETER_SYNC_OFF];
        out_valid_ff   <= chan_ctrl_ff[`DDCCFG_CHAN_EN] & ~chan_ctrl_ff[`DDCCFG_COEF_READ];
        if (run) begin
            // Alternating A, B positions in the interleaved stream
            phase_ff <= chan_ctrl_ff[`DDCCFG_INTERLEAVE] & ~phase_ff;
            dither_out_ff <= chan_ctrl_ff[`DDCCFG_DITHER_EN] ?
                (dither_word & {~chan_ctrl_ff[`DDCCFG_DITHER_MSK_HI],
                                ~chan_ctrl_ff[`DDCCFG_DITHER_MSK_LO], 14'h3fff}) :
                16'h0000;
            if (take) begin
                mix_in_i_ff <= mux_i;
                mix_in_q_ff <= chan_ctrl_ff[`DDCCFG_Q_ZERO] ? 18'h00000 : mux_q;
            end
            mix_out_i_ff <= (boost_i[18] != boost_i[17]) ?
                {boost_i[18], {17{~boost_i[18]}}} : boost_i[17:0];
            mix_out_q_ff <= (boost_q[18] != boost_q[17]) ?
                {boost_q[18], {17{~boost_q[18]}}} : boost_q[17:0];
        end
    end
end

// ----------------------------------------------------------------------
// Gain control loop
// ----------------------------------------------------------------------
reg  [23:0] acc_ff;
reg  [3:0]  sat_run_ff;
reg  [3:0]  zero_run_ff;
reg  [41:0] prod;
reg  [17:0] mag;
reg  [17:0] rnd_out;
reg  [7:0]  top8;
reg  [3:0]  shift;
reg         add_dir;
reg  [24:0] step;
reg  [25:0] hi_lim;
reg  [25:0] lo_lim;
reg  [25:0] acc_nxt;
reg  [25:0] clamp;
wire [3:0]  rnd_bits = mask_rnd_ff[11:8];
wire        hold = hold_runs_ff[`DDCCFG_HOLD_BIT];
wire        zero_now = (mag == 18'h00000);
wire        sat_now = (mag >= `DDCCFG_FULL_SCALE);

// Product, rounding, magnitude, step choice and clamp
always @* begin
    prod = {{24{agc_in_i[17]}}, agc_in_i} * {18'h00000, gain_applied_ff};
    // Drop 12 fraction bits, round to 18 minus round field bits
    rnd_out = prod[29:12] & ~((18'h00001 << rnd_bits) - 18'h00001);
    mag = rnd_out[17] ? (~rnd_out + 18'h00001) : rnd_out;
    mag = mag & {14'h3fff, ~mask_rnd_ff[15:12]};
    top8 = mag[16:9];
    if (sat_run_ff == hold_runs_ff[11:8] && hold_runs_ff[11:8] != 4'h0) begin
        shift = step_shift_ff[3:0];
        add_dir = 1'b0;
    end else if (zero_run_ff == hold_runs_ff[3:0] && hold_runs_ff[3:0] != 4'h0) begin
        shift = step_shift_ff[7:4];
        add_dir = 1'b1;
    end else if (top8 < mask_rnd_ff[7:0]) begin
        shift = step_shift_ff[15:12];
        add_dir = 1'b1;
    end else begin
        shift = step_shift_ff[11:8];
        add_dir = 1'b0;
    end
    step = {1'b0, gain_applied_ff >> shift};
    hi_lim = {2'b00, gain_a_live_ff} + {10'h000, rise_limit_ff};
    lo_lim = {2'b00, gain_a_live_ff} - {10'h000, fall_limit_ff};
    if (lo_lim[25]) begin
        lo_lim = 26'h0000000;
    end
    acc_nxt = add_dir ? ({2'b00, acc_ff} + {1'b0, step}) :
                        ({2'b00, acc_ff} - {1'b0, step});
    clamp = acc_nxt;
    if (acc_nxt[25] || acc_nxt < lo_lim) begin
        clamp = lo_lim;
    end else if (acc_nxt > hi_lim) begin
        clamp = hi_lim;
    end
    if (clamp[24]) begin
        clamp = 26'h0ffffff;
    end
end

// Accumulator, run counters, applied gain, outputs
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        acc_ff          <= `DDCCFG_RST24;
        sat_run_ff      <= 4'h0;
        zero_run_ff     <= 4'h0;
        gain_applied_ff <= `DDCCFG_RST24;
        agc_out_i_ff    <= 18'h00000;
        agc_out_q_ff    <= 18'h00000;
        sat_seen_ff     <= 1'b0;
        sync_prev_ff    <= 1'b0;
    end else if (run) begin
        sync_prev_ff <= gain_load;
        agc_out_i_ff <= rnd_out;
        agc_out_q_ff <= agc_in_q;
        sat_seen_ff  <= sat_seen_ff | sat_now;
        sat_run_ff   <= sat_now ? ((sat_run_ff == hold_runs_ff[11:8]) ? sat_run_ff :
                        sat_run_ff + 4'h1) : 4'h0;
        zero_run_ff  <= zero_now ? ((zero_run_ff == hold_runs_ff[3:0]) ? zero_run_ff :
                        zero_run_ff + 4'h1) : 4'h0;
        if (hold_runs_ff[`DDCCFG_CLEAR_BIT]) begin
            acc_ff          <= gain_a_live_ff;
            gain_applied_ff <= gain_a_live_ff;
        end else if (gain_load && !sync_prev_ff) begin
            acc_ff          <= {gain_upper_ff[15:8], gain_a_low_ff};
            gain_applied_ff <= {gain_upper_ff[15:8], gain_a_low_ff};
        end else if (!hold) begin
            acc_ff          <= clamp[23:0];
            gain_applied_ff <= clamp[23:0];
        end
    end
end

// ----------------------------------------------------------------------
// Probe bus
// ----------------------------------------------------------------------
reg [35:0] probe_nxt;

// Probe selection; constant zero holds the bus still
always @* begin
    case (probe_ctrl_ff[5:0])
        `DDCCFG_PRB_PULSE:  probe_nxt = tap_pulse;
        `DDCCFG_PRB_COMP:   probe_nxt = tap_comp;
        `DDCCFG_PRB_TADJ_A: probe_nxt = tap_tadj_a;
        `DDCCFG_PRB_TADJ_B: probe_nxt = tap_tadj_b;
        `DDCCFG_PRB_SINE:   probe_nxt = {16'h0000, tap_sine};
        `DDCCFG_PRB_COSINE: probe_nxt = {16'h0000, tap_cosine};
        `DDCCFG_PRB_CIC:    probe_nxt = tap_cic;
        `DDCCFG_PRB_AGC:    probe_nxt = {agc_out_i_ff, agc_out_q_ff};
        `DDCCFG_PRB_MIX_A:  probe_nxt = {mix_out_i_ff, mix_out_q_ff};
        `DDCCFG_PRB_MIX_B:  probe_nxt = tap_mix_b;
        `DDCCFG_PRB_MUX_A:  probe_nxt = {mix_in_i_ff, mix_in_q_ff};
        `DDCCFG_PRB_MUX_B:  probe_nxt = {mux_i, mux_q};
        default:            probe_nxt = 36'h000000000;
    endcase
end

// Probe register keeps clocking; its input is simply frozen at zero
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        probe_bus_ff      <= 36'h000000000;
        probe_sync_ff     <= 1'b0;
        probe_agc_flag_ff <= 1'b0;
    end else if (clk_en) begin
        probe_bus_ff <= probe_nxt;
        if (probe_ctrl_ff[5:0] == `DDCCFG_PRB_PULSE ||
            probe_ctrl_ff[5:0] == `DDCCFG_PRB_COMP ||
            probe_ctrl_ff[5:0] == `DDCCFG_PRB_AGC) begin
            probe_sync_ff     <= filt_sync;
            probe_agc_flag_ff <= sat_now;
        end else begin
            probe_sync_ff     <= 1'b0;
            probe_agc_flag_ff <= 1'b0;
        end
    end
end

endmodule

// [tb/ddccfg_properties.sv]
/*
 * Port-level checks for the channel configuration and gain block.
 * Assumes one clock domain; bound to the top module from the bench.
 */
`timescale 1ns/1ps
`include "ddccfg_defines.vh"

module ddccfg_properties (
    input logic        clk,
    input logic        nrst,
    input logic        clk_en,
    input logic [4:0]  reg_addr,
    input logic        reg_rd,
    input logic [15:0] reg_rdata_ff,
    input logic        pmeter_sync_in,
    input logic        pmeter_sync_ff,
    input logic [15:0] dither_word,
    input logic [15:0] dither_out_ff,
    input logic        chan_run_ff,
    input logic        out_valid_ff,
    input logic [17:0] mixer_i,
    input logic [17:0] mixer_q,
    input logic [17:0] mix_out_i_ff,
    input logic [17:0] mix_out_q_ff,
    input logic [17:0] agc_in_q,
    input logic [17:0] agc_out_q_ff
);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // Channel ran in this cycle and the one before
    sequence run2;
        $past(clk_en) && chan_run_ff && $past(chan_run_ff);
    endsequence

    a_meter_sync_gate: assert property ($past(clk_en) && pmeter_sync_ff |->
        $past(pmeter_sync_in))
        else $error("Meter sync without an input sync");
    a_valid_needs_run: assert property (out_valid_ff |-> chan_run_ff)
        else $error("Output valid while channel stopped");
    a_read_idle_zero: assert property (!reg_rd && clk_en |=> reg_rdata_ff == 16'h0000)
        else $error("Read data outside the answer cycle");
    a_probe_high_zero: assert property (reg_rd && clk_en &&
        reg_addr == `DDCCFG_OFS_PROBE_CTRL ##1 out_valid_ff |-> reg_rdata_ff[15:6] == 10'h000)
        else $error("Probe select reads reserved bits");
    a_dither_bits_kept: assert property (run2 |-> (dither_out_ff & ~$past(dither_word)) == 0)
        else $error("Dither holds bits not in the word");
    a_mix_sign_i: assert property (run2 |-> mix_out_i_ff[17] == $past(mixer_i[17]))
        else $error("Mixer I sign lost");
    a_mix_sign_q: assert property (run2 |-> mix_out_q_ff[17] == $past(mixer_q[17]))
        else $error("Mixer Q sign lost");
    a_gain_q_pass: assert property (run2 |-> agc_out_q_ff == $past(agc_in_q))
        else $error("Gain Q path not passed");

    // Main scenarios reached
    cover property (reg_rd ##1 reg_rdata_ff != 16'h0000);
    cover property (pmeter_sync_ff);
    cover property ($rose(out_valid_ff));
endmodule

// [tb/testbench.sv]
/*
 * Self-checking bench for the channel configuration and gain block.
 * Assumes the design top and its defines header on the include path.
 */
`timescale 1ns/1ps
`include "ddccfg_defines.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end

module testbench;
    logic        clk, nrst, clk_en, reg_wr, reg_rd, chan_sync_count, pmeter_sync_in, filt_sync;
    logic [4:0]  reg_addr;
    logic [15:0] reg_wdata, coef_rdata, dither_word, reg_rdata_ff, dither_out_ff, c;
    logic [3:0]  rx_sync_pins;
    logic [17:0] mux_i, mux_q, mixer_i, mixer_q, agc_in_i, agc_in_q, agc_lvl, m;
    logic [19:0] tap_sine, tap_cosine;
    logic [35:0] tap_pulse, tap_comp, tap_tadj_a, tap_tadj_b, tap_cic, tap_mix_b, probe_bus_ff;
    logic        chan_run_ff, pmeter_sync_ff, out_valid_ff, probe_sync_ff, probe_agc_flag_ff;
    logic [17:0] mix_in_i_ff, mix_in_q_ff, mix_out_i_ff, mix_out_q_ff, agc_out_i_ff, agc_out_q_ff;
    logic [23:0] gain_applied_ff, g, g0;
    logic [10:0] spare;
    logic        hold_in, p;
    int          n_mismatch = 0;
    int          n_compared = 0;

    ddccfg_top u_ddccfg_top (.*);

    // ------------------------------------------------------------
    // Clock, stimulus and bus tasks
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    function automatic logic [35:0] r36();
        logic [63:0] t;
        t = {$urandom, $urandom};
        return t[35:0];
    endfunction
    task automatic shuffle();
        {mux_i, mux_q} <= r36();
        {mixer_i, mixer_q} <= r36();
        {tap_pulse, tap_comp, tap_tadj_a} <= {r36(), r36(), r36()};
        {tap_tadj_b, tap_cic, tap_mix_b} <= {r36(), r36(), r36()};
        {tap_sine, tap_cosine, dither_word, coef_rdata} <= {r36(), r36()};
        {filt_sync, pmeter_sync_in, chan_sync_count, rx_sync_pins, agc_in_q, spare} <= r36();
        agc_in_i <= agc_lvl;
    endtask
    // Fresh random samples each cycle unless frozen
    always @(posedge clk) begin
        if (!hold_in) begin
            shuffle();
        end
    end
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        settle(1);
    endtask
    task automatic rdc(input logic [4:0] a, input logic [15:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata_ff, e)
        settle(1);
    endtask

    // ------------------------------------------------------------
    // Expected values
    // ------------------------------------------------------------
    function automatic logic [17:0] boost(input logic b, input logic [17:0] x);
        if (!b) return x;
        if (x[17] != x[16]) return x[17] ? 18'h20000 : `DDCCFG_FULL_SCALE;
        return {x[16:0], 1'b0};
    endfunction
    function automatic logic [35:0] probe(input logic [5:0] s);
        case (s)
            6'h01: return tap_pulse;
            6'h02: return tap_comp;
            6'h03: return tap_tadj_a;
            6'h04: return tap_tadj_b;
            6'h05: return {16'h0000, tap_sine};
            6'h06: return {16'h0000, tap_cosine};
            6'h07: return tap_cic;
            6'h08: return {18'h0, agc_in_q};
            6'h09: return {boost(1'b1, mixer_i), boost(1'b1, mixer_q)};
            6'h0a: return tap_mix_b;
            6'h0b: return {mux_i, 18'h0};
            6'h0c: return {mux_i, mux_q};
            default: return 36'h0;
        endcase
    endfunction
    task automatic end_of_test();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        logic [4:0]  ofs [8] = '{5'h0e, 5'h0f, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16};
        logic [15:0] msk [8] = '{16'hfe07, 16'h003f, 16'hffff, 16'h1f1f,
                                 16'hffff, 16'hffff, 16'hffff, 16'hffff};
        logic [5:0]  s;
        void'($urandom(22130));
        {nrst, reg_wr, reg_rd, hold_in, reg_addr, reg_wdata, agc_lvl} = '0;
        clk_en = 1'b1;
        shuffle();
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        settle(3);
        for (int i = 0; i < 8; i++) begin
            rdc(ofs[i], 16'h0000);
        end
        rdc(5'h00, 16'h0000);
        for (int i = 0; i < 16; i++) begin
            c = 16'($urandom) & msk[i % 8];
            if (i % 8 == 0) c[1] = c[1] & c[0];
            wr(ofs[i % 8], c);
            rdc(ofs[i % 8], c);
        end
        hold_in = 1'b1;
        wr(`DDCCFG_OFS_CHAN_CTRL, 16'h0900);
        rdc(`DDCCFG_OFS_STEP_SHIFT, coef_rdata);
        `CHK(out_valid_ff, 1'b0)
        for (int i = 0; i < 8; i++) begin
            wr(`DDCCFG_OFS_CHAN_CTRL, {i[2:0], 3'b010, i[0], 6'h00, i[1], 2'b00});
            `CHK(dither_out_ff, i[2] ? dither_word & ~{i[1:0], 14'h0} : 16'h0)
            `CHK(mix_out_i_ff, boost(i[0], mixer_i))
            `CHK(mix_in_q_ff, i[1] ? 18'h0 : mux_q)
            `CHK(mix_in_i_ff, mux_i)
            `CHK({chan_run_ff, out_valid_ff}, 2'b11)
        end
        for (int k = 0; k < 13; k++) begin
            s = 6'(k);
            wr(`DDCCFG_OFS_PROBE_CTRL, {10'h000, s});
            `CHK(probe_bus_ff, probe(s))
            p = filt_sync && (s == 6'h01 || s == 6'h02 || s == 6'h08);
            `CHK({probe_sync_ff, probe_agc_flag_ff}, {p, 1'b0})
        end
        wr(`DDCCFG_OFS_CHAN_CTRL, 16'h0000);
        `CHK(chan_run_ff, 1'b0)
        hold_in = 1'b0;
        for (int j = 0; j < 2; j++) begin
            wr(`DDCCFG_OFS_CHAN_CTRL, j ? 16'h0800 : 16'h1800);
            p = pmeter_sync_in;
            repeat (30) begin
                settle(1);
                `CHK(pmeter_sync_ff, j ? p : 1'b0)
                p = pmeter_sync_in;
            end
        end
        wr(`DDCCFG_OFS_CHAN_CTRL, 16'h0c03);
        p = 1'b0;
        repeat (20) begin
            m = mux_i;
            settle(1);
            p = !p;
            `CHK(mix_in_i_ff == m, p)
        end
        m = mix_out_i_ff;
        clk_en <= 1'b0;
        settle(3);
        `CHK(mix_out_i_ff, m)
        clk_en <= 1'b1;
        wr(`DDCCFG_OFS_RISE_LIMIT, 16'h0000);
        wr(`DDCCFG_OFS_FALL_LIMIT, 16'h0000);
        wr(`DDCCFG_OFS_SYNC_SEL, 16'h0060);
        wr(`DDCCFG_OFS_HOLD_RUNS, 16'h0000);
        wr(`DDCCFG_OFS_STEP_SHIFT, 16'h3333);
        wr(`DDCCFG_OFS_MASK_RND, 16'h00ff);
        g0 = gain_applied_ff;
        g = 24'h001000 | 24'($urandom & 32'hfff);
        wr(`DDCCFG_OFS_GAIN_UPPER, {g[23:16], 8'h00});
        wr(`DDCCFG_OFS_GAIN_A_LOW, g[15:0]);
        `CHK(gain_applied_ff, g0)
        wr(`DDCCFG_OFS_SYNC_SEL, 16'h0050);
        settle(4);
        `CHK(gain_applied_ff, g)
        repeat (40) begin
            settle(1);
            `CHK(gain_applied_ff, g)
        end
        wr(`DDCCFG_OFS_RISE_LIMIT, 16'h0200);
        wr(`DDCCFG_OFS_FALL_LIMIT, 16'h0200);
        agc_lvl = 18'h00100;
        settle(60);
        `CHK(gain_applied_ff, g + 24'h000200)
        wr(`DDCCFG_OFS_MASK_RND, 16'h0000);
        agc_lvl = `DDCCFG_FULL_SCALE;
        settle(60);
        `CHK(gain_applied_ff, g - 24'h000200)
        wr(`DDCCFG_OFS_HOLD_RUNS, 16'h1000);
        wr(`DDCCFG_OFS_MASK_RND, 16'h00ff);
        agc_lvl = 18'h00100;
        settle(30);
        `CHK(gain_applied_ff, g - 24'h000200)
        wr(`DDCCFG_OFS_HOLD_RUNS, 16'h1010);
        settle(4);
        `CHK(gain_applied_ff, g)
        end_of_test();
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        end_of_test();
    end
endmodule

bind ddccfg_top ddccfg_properties u_ddccfg_properties (.*);
